// >>> dacc_defs.vh
`ifndef DACC_DEFS_VH
`define DACC_DEFS_VH

// ---------------------------------------------------------------
// word layout
// ---------------------------------------------------------------
`define DACC_WORD_W      16
`define DACC_BIT_SUB     15
`define DACC_BIT_MD0     14
`define DACC_BIT_MD1     13
`define DACC_ADDR_HI     12
`define DACC_ADDR_LO     10
`define DACC_BIT_CODING  6
`define DACC_BIT_PD      5
`define DACC_BIT_GLOBAL_STANDBY   4
`define DACC_BIT_GLOBAL_SOFT_CLEAR    3
`define DACC_BIT_MX1     9
`define DACC_BIT_MX0     8
`define DACC_BIT_CHANNEL_STANDBY_N    4
`define DACC_BIT_CLR     3
`define DACC_MAIN_HI     9
`define DACC_MAIN_LO     0
`define DACC_SUB_HI      9
`define DACC_SUB_LO      2

// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define DACC_RST_PD      1'b1
`define DACC_RST_GLOBAL_STANDBY   1'b1
`define DACC_RST_CODING  1'b0
`define DACC_RST_GLOBAL_SOFT_CLEAR    1'b0
`define DACC_RST_CHANNEL_STANDBY_N    1'b1
`define DACC_RST_CLR     1'b1
`define DACC_RST_REFSEL  2'h0
`define DACC_RST_MAIN    10'h000
`define DACC_RST_SUB     8'h00
`define DACC_CLR_TWOS    10'h000
`define DACC_CLR_BIN     10'h000
`define DACC_REF_HALF    2'h0
`define DACC_REF_INT     2'h1
`define DACC_REF_EXT     2'h2
`define DACC_LAST_BIT    4'hF
`endif

// >>> dacc_host.sv
// ----------------------------------------
// serial host
// ----------------------------------------
module dacc_host (
   input  wire  clk,
   output logic serial_clk = 1'b1,
   output logic serial_data = 1'b0,
   output logic frame_sync_n = 1'b1,
   output logic load_outputs_strobe_n = 1'b1
);
   timeunit 1ns;
   timeprecision 100ps;
   // link clock stands high outside frames; data moves on its rise
   // nbits below 16 cuts the frame short
   task automatic send(input logic [15:0] w, input int nbits = 16);
      @(negedge clk);
      frame_sync_n = 1'b0;
      repeat (6) @(negedge clk);
      // offset keeps every link edge clear of the sampling clock edge
      #1;
      for (int i = 15; i > 15 - nbits; i--) begin
         serial_data = w[i];
         #62.5 serial_clk = 1'b0;
         #62.5 serial_clk = 1'b1;
      end
      frame_sync_n = 1'b1;
      serial_data = ~serial_data;
   endtask
   task automatic pulse_load;
      @(negedge clk);
      load_outputs_strobe_n = 1'b0;
      repeat (8) @(negedge clk);
      load_outputs_strobe_n = 1'b1;
      repeat (8) @(negedge clk);
   endtask
endmodule

// >>> dacc_top.v
`include "dacc_defs.vh"

module dacc_top #(
   parameter NUM_CH = 8
) (
   // clock and reset
   input  wire                  clk,
   input  wire                  reset_n,
   // serial link pins
   input  wire                  serial_clk,
   input  wire                  serial_data,
   input  wire                  frame_sync_n,
   input  wire                  load_outputs_strobe_n,
   // global state
   output reg                   reference_enable,
   output reg                   input_coding_select,
   // per channel state
   output reg  [NUM_CH-1:0]     channel_enable,
   output reg  [2*NUM_CH-1:0]   ref_select,
   output reg  [10*NUM_CH-1:0]  main_dac_code,
   output reg  [10*NUM_CH-1:0]  main_level,
   output reg  [8*NUM_CH-1:0]   sub_offset
);

   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_SHIFT = 3'h2;
   localparam [2:0] ST_DONE  = 3'h4;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function [9:0] clear_code;
      input coding;
      begin
         clear_code = coding ? `DACC_CLR_BIN : `DACC_CLR_TWOS;
      end
   endfunction

   function [2:0] chan_index;
      input [2:0] addr;
      begin
         if (NUM_CH == 4) begin
            chan_index = {1'b0, addr[1:0]};
         end else begin
            chan_index = addr;
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // order: 3 strobe, 2 sync, 1 data, 0 clock
   wire [3:0] pins_in = {load_outputs_strobe_n, frame_sync_n, serial_data, serial_clk};
   reg  [3:0] pin_s1;
   reg  [3:0] pin_s2;
   reg  [3:0] pin_s3;
   reg  [3:0] pin_f;
   reg  [3:0] pin_f_d;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1  <= 4'hF;
         pin_s2  <= 4'hF;
         pin_s3  <= 4'hF;
         pin_f   <= 4'hF;
         pin_f_d <= 4'hF;
      end else begin
         pin_s1  <= pins_in;
         pin_s2  <= pin_s1;
         pin_s3  <= pin_s2;
         // hold the filtered level while the second and third flops disagree
         pin_f   <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
         pin_f_d <= pin_f;
      end
   end

   // data and clock share the same delay, so data stays aligned
   wire sclk_fall   = pin_f_d[0] & ~pin_f[0];
   wire sdin_f      = pin_f[1];
   wire sync_n_f    = pin_f[2];
   wire strobe_fall = pin_f_d[3] & ~pin_f[3];

   // ---------------------------------------------------------------
   // frame receiver
   // ---------------------------------------------------------------
   reg [2:0]  state;
   reg [3:0]  bit_cnt;
   reg [14:0] shift_reg;
   reg [15:0] rx_word;
   reg        word_done;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state     <= ST_IDLE;
         bit_cnt   <= 4'h0;
         shift_reg <= 15'h0000;
         rx_word   <= 16'h0000;
         word_done <= 1'b0;
      end else begin
         word_done <= 1'b0;
         case (state)
            ST_IDLE: begin
               bit_cnt <= 4'h0;
               if (!sync_n_f) begin
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               // a short frame is dropped, never half decoded
               if (sync_n_f) begin
                  state <= ST_IDLE;
               end else if (sclk_fall) begin
                  shift_reg <= {shift_reg[13:0], sdin_f};
                  bit_cnt   <= bit_cnt + 4'h1;
                  if (bit_cnt == `DACC_LAST_BIT) begin
                     rx_word   <= {shift_reg, sdin_f};
                     word_done <= 1'b1;
                     state     <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               // extra bits after the 16th are ignored
               if (sync_n_f) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // word decode
   // ---------------------------------------------------------------
   wire       is_system  = ~rx_word[`DACC_BIT_MD1] & ~rx_word[`DACC_BIT_MD0];
   wire       is_channel = ~rx_word[`DACC_BIT_MD1] &  rx_word[`DACC_BIT_MD0];
   wire       is_data    =  rx_word[`DACC_BIT_MD1];
   wire [2:0] word_addr  = rx_word[`DACC_ADDR_HI:`DACC_ADDR_LO];
   wire [2:0] sel        = chan_index(word_addr);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg        power_down_n;
   reg        coding;
   reg        global_standby;
   reg        global_soft_clear;
   reg        channel_standby_n  [0:NUM_CH-1];
   reg        channel_soft_clear [0:NUM_CH-1];
   reg [1:0]  ref_sel            [0:NUM_CH-1];
   reg [9:0]  main_data          [0:NUM_CH-1];
   reg [9:0]  main_dac           [0:NUM_CH-1];
   reg [7:0]  sub_data           [0:NUM_CH-1];
   reg [7:0]  sub_dac            [0:NUM_CH-1];
   integer    i;
   integer    j;

   // contents survive power-down: nothing here looks at power_down_n
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         power_down_n      <= `DACC_RST_PD;
         global_standby    <= `DACC_RST_GLOBAL_STANDBY;
         coding            <= `DACC_RST_CODING;
         global_soft_clear <= `DACC_RST_GLOBAL_SOFT_CLEAR;
         for (i = 0; i < NUM_CH; i = i + 1) begin
            channel_standby_n[i]  <= `DACC_RST_CHANNEL_STANDBY_N;
            channel_soft_clear[i] <= `DACC_RST_CLR;
            ref_sel[i]            <= `DACC_RST_REFSEL;
            main_data[i]          <= `DACC_RST_MAIN;
            main_dac[i]           <= `DACC_RST_MAIN;
            sub_data[i]           <= `DACC_RST_SUB;
            sub_dac[i]            <= `DACC_RST_SUB;
         end
      end else begin
         if (word_done && is_system) begin
            // address field deliberately unused here
            power_down_n      <= rx_word[`DACC_BIT_PD];
            coding            <= rx_word[`DACC_BIT_CODING];
            global_standby    <= rx_word[`DACC_BIT_GLOBAL_STANDBY];
            global_soft_clear <= rx_word[`DACC_BIT_GLOBAL_SOFT_CLEAR];
         end
         if (word_done && is_channel) begin
            channel_standby_n[sel]  <= rx_word[`DACC_BIT_CHANNEL_STANDBY_N];
            channel_soft_clear[sel] <= rx_word[`DACC_BIT_CLR];
            ref_sel[sel]            <= {rx_word[`DACC_BIT_MX1],
                                        rx_word[`DACC_BIT_MX0]};
         end
         if (word_done && is_data) begin
            if (rx_word[`DACC_BIT_SUB]) begin
               sub_data[sel] <= rx_word[`DACC_SUB_HI:`DACC_SUB_LO];
            end else begin
               main_data[sel] <= rx_word[`DACC_MAIN_HI:`DACC_MAIN_LO];
            end
         end
         for (i = 0; i < NUM_CH; i = i + 1) begin
            if (strobe_fall) begin
               sub_dac[i] <= sub_data[i];
               if (channel_soft_clear[i]) begin
                  // channel clear only acts on the strobe
                  main_data[i] <= clear_code(coding);
                  main_dac[i]  <= clear_code(coding);
               end else begin
                  main_dac[i] <= main_data[i];
               end
            end
            if (global_soft_clear) begin
               // level acting: holds main side cleared while set, subs untouched
               main_data[i] <= clear_code(coding);
               main_dac[i]  <= clear_code(coding);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // output stage
   // ---------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reference_enable    <= 1'b1;
         input_coding_select <= `DACC_RST_CODING;
         channel_enable      <= {NUM_CH{1'b0}};
         ref_select          <= {2*NUM_CH{1'b0}};
         main_dac_code       <= {10*NUM_CH{1'b0}};
         main_level          <= {10*NUM_CH{1'b0}};
         sub_offset          <= {8*NUM_CH{1'b0}};
      end else begin
         reference_enable    <= power_down_n;
         input_coding_select <= coding;
         for (j = 0; j < NUM_CH; j = j + 1) begin
            channel_enable[j] <= power_down_n & ~global_standby
                                 & channel_standby_n[j];
            ref_select[2*j +: 2]    <= ref_sel[j];
            main_dac_code[10*j +: 10] <= main_dac[j];
            // unsigned level: offset binary as is, twos complement MSB flipped
            main_level[10*j +: 10] <= coding ? main_dac[j]
                                      : {~main_dac[j][9], main_dac[j][8:0]};
            // signed offset: offset binary minus 128 equals MSB flip
            sub_offset[8*j +: 8] <= coding ? {~sub_dac[j][7], sub_dac[j][6:0]}
                                    : sub_dac[j];
         end
      end
   end

endmodule

// >>> dacc_top_bench.sv
module dacc_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int N = 8;
   logic            clk = 1'b0;
   logic            reset_n = 1'b0;
   wire             sclk, sdat, sync_n, ld_n, ref_en, coding_o;
   wire [N-1:0]     ch_en;
   wire [2*N-1:0]   ref_sel;
   wire [10*N-1:0]  code, level;
   wire [8*N-1:0]   sub;
   int              miscompares = 0;
   int              n_checks = 0;
   int              cycles = 0;
   logic [31:0]     seed = 32'h9A3E;
   logic            pd, gstby, coding, gclr;
   logic [N-1:0]    channel_standby_n_n, clr;
   logic [1:0]      refs [N];
   logic [9:0]      mdata [N], mdac [N];
   logic [7:0]      sdata [N], sdac [N];

   dacc_top #(.NUM_CH(N)) dacc_top_i (.clk(clk), .reset_n(reset_n), .serial_clk(sclk),
      .serial_data(sdat), .frame_sync_n(sync_n), .load_outputs_strobe_n(ld_n),
      .reference_enable(ref_en), .input_coding_select(coding_o), .channel_enable(ch_en),
      .ref_select(ref_sel), .main_dac_code(code), .main_level(level), .sub_offset(sub));
   dacc_host dacc_host_i (.clk(clk), .serial_clk(sclk), .serial_data(sdat),
      .frame_sync_n(sync_n), .load_outputs_strobe_n(ld_n));

   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         complete_run();
      end
   end
   // ----------------------------------------
   // expectations
   // ----------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [9:0] lvl(input logic [9:0] c, input logic b);
      return b ? c : {~c[9], c[8:0]};
   endfunction
   function automatic logic [7:0] soff(input logic [7:0] c, input logic b);
      return b ? {~c[7], c[6:0]} : c;
   endfunction
   task automatic compare(input string what, input logic [79:0] exp, input logic [79:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic write(input logic [15:0] w);
      int a;
      a = w[12:10];
      dacc_host_i.send(w);
      repeat (12) @(negedge clk);
      if (w[13]) begin
         if (w[15]) sdata[a] = w[9:2];
         else mdata[a] = w[9:0];
      end else if (w[14]) begin
         refs[a] = w[9:8];
         channel_standby_n_n[a] = w[4];
         clr[a] = w[3];
      end else begin
         coding = w[6];
         pd = w[5];
         gstby = w[4];
         gclr = w[3];
      end
      // global clear is a level: later main writes do not stick
      if (gclr) begin
         mdata = '{default: '0};
         mdac = '{default: '0};
      end
   endtask
   task automatic load;
      dacc_host_i.pulse_load();
      for (int i = 0; i < N; i++) begin
         if (clr[i]) mdata[i] = 10'h000;
         mdac[i] = mdata[i];
         sdac[i] = sdata[i];
      end
   endtask
   task automatic check_all;
      logic [79:0] md, lv;
      logic [63:0] so;
      logic [15:0] rs;
      logic [7:0]  en;
      for (int i = 0; i < N; i++) begin
         md[10*i +: 10] = mdac[i];
         lv[10*i +: 10] = lvl(mdac[i], coding);
         so[8*i +: 8] = soff(sdac[i], coding);
         rs[2*i +: 2] = refs[i];
         en[i] = pd & ~gstby & channel_standby_n_n[i];
      end
      compare("reference_enable", 80'(pd), 80'(ref_en));
      compare("input_coding_select", 80'(coding), 80'(coding_o));
      compare("channel_enable", 80'(en), 80'(ch_en));
      compare("ref_select", 80'(rs), 80'(ref_sel));
      compare("main_dac_code", md, code);
      compare("main_level", lv, level);
      compare("sub_offset", 80'(so), 80'(sub));
   endtask
   task automatic complete_run;
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      {pd, gstby, coding, gclr} = 4'h C;
      channel_standby_n_n = '1;
      clr = '1;
      refs = '{default: '0};
      mdata = '{default: '0};
      mdac = '{default: '0};
      sdata = '{default: '0};
      sdac = '{default: '0};
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      repeat (8) @(negedge clk);
      check_all();
      write({3'b000, seed[2:0], 10'h060});
      check_all();
      for (int i = 0; i < N; i++) begin
         seed = xorshift(seed);
         write({3'b010, 3'(i), 2'(i), 3'b000, seed[0], 4'h0});
      end
      check_all();
      load();
      for (int k = 0; k < 24; k++) begin
         seed = xorshift(seed);
         write({seed[15:14], 1'b1, seed[12:0]});
         if (seed[20]) load();
         check_all();
      end
      write({3'b010, 3'd3, 10'h118});
      check_all();
      load();
      check_all();
      write({3'b010, 3'd3, 10'h110});
      write(16'h2C77);
      load();
      check_all();
      dacc_host_i.send(16'hA3FC, 9);
      load();
      check_all();
      write(16'h0068);
      check_all();
      write(16'h2455);
      check_all();
      write(16'h0020);
      check_all();
      write(16'h0000);
      check_all();
      write(16'h0060);
      check_all();
      complete_run();
   end
endmodule

// >>> dacc_top_sva.sv
// ----------------------------------------
// port checks
// ----------------------------------------
module dacc_top_sva #(
   parameter NUM_CH = 8
) (
   input wire                  clk,
   input wire                  reset_n,
   input wire                  frame_sync_n,
   input wire                  load_outputs_strobe_n,
   input wire                  reference_enable,
   input wire                  input_coding_select,
   input wire [NUM_CH-1:0]     channel_enable,
   input wire [2*NUM_CH-1:0]   ref_select,
   input wire [10*NUM_CH-1:0]  main_dac_code,
   input wire [10*NUM_CH-1:0]  main_level,
   input wire [8*NUM_CH-1:0]   sub_offset
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int T = 10*NUM_CH-10;
   reg [3:0] since_evt;
   // pins are synchronised, so allow ten cycles after any frame or strobe
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         since_evt <= 4'h0;
      else if (!frame_sync_n || !load_outputs_strobe_n)
         since_evt <= 4'h0;
      else if (since_evt != 4'hF)
         since_evt <= since_evt + 4'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_reset_state: assert property ($rose(reset_n) |-> reference_enable
      && !input_coding_select && ref_select == '0 && main_dac_code == '0)
      else $error("state wrong after reset");
   chk_powerup_idle: assert property ($rose(reset_n) |-> (channel_enable == '0) [*8])
      else $error("channel enabled at power up");
   chk_pd_off: assert property (!reference_enable |-> channel_enable == '0)
      else $error("channel enabled while powered down");
   chk_level_low: assert property (since_evt > 4'hA |-> main_level[9:0] ==
      (input_coding_select ? main_dac_code[9:0] : {~main_dac_code[9], main_dac_code[8:0]}))
      else $error("level of first channel wrong");
   chk_level_top: assert property (since_evt > 4'hA |-> main_level[T +: 10] ==
      (input_coding_select ? main_dac_code[T +: 10] : main_dac_code[T +: 10] ^ 10'h200))
      else $error("level of last channel wrong");
   chk_ctrl_quiet: assert property (since_evt > 4'hA |-> $stable(ref_select) &&
      $stable(channel_enable) && $stable(input_coding_select))
      else $error("control output changed without a write");
   chk_main_cause: assert property ($changed(main_dac_code) |-> since_evt <= 4'hA)
      else $error("main code changed without a write or load");
   chk_sub_cause: assert property ($changed(sub_offset) |-> since_evt <= 4'hA)
      else $error("sub offset changed without a write or load");
endmodule

bind dacc_top dacc_top_sva #(.NUM_CH(NUM_CH)) dacc_top_sva_i (
   .clk(clk), .reset_n(reset_n), .frame_sync_n(frame_sync_n),
   .load_outputs_strobe_n(load_outputs_strobe_n), .reference_enable(reference_enable),
   .input_coding_select(input_coding_select), .channel_enable(channel_enable),
   .ref_select(ref_select), .main_dac_code(main_dac_code), .main_level(main_level),
   .sub_offset(sub_offset));
